// file: alb_defs.vh
// constants of the add / logic / branch execute slice
// How it works
// - add-immediate writes first source plus sign-extended literal to destination, one cycle
// - bit 3 set keeps carry; clear loads carry out of the addition
// - bit 4 set adds current carry flag into sum; clear ignores it
// - keep-carry sets bit 3, carry-in sets bit 4, combined form sets both
// - literal is sign-extended unless an upper-half prefix directly precedes it
// - register AND writes first source AND second source in one cycle
// - immediate AND writes first source AND sign-extended literal in one cycle
// - register AND-NOT writes first source AND complement of second source
// - immediate AND-NOT sign-extends, complements, then ANDs literal with first source
// - register branch-if-zero loads PC plus second source when first source is zero
// - untaken branch advances the program counter by four
// - immediate branch-if-zero adds sign-extended literal to PC when first source zero
// - greater-or-equal branch taken when signed first source is not negative
// - delay flag set lets the following instruction complete before the target
// - delay flag clear discards the following instruction; target executes next
// - branch takes 1 cycle untaken, 2 taken with delay, 3 taken without
// - immediate format: opcode bit 0, destination 6, first source 11, literal 16-31
// - register format: opcode, destination and two source register fields
`ifndef ALB_DEFS_VH
`define ALB_DEFS_VH

// ----------------------------------------------------------------
// instruction fields (bit 0 of the printed format is word bit 31)
// ----------------------------------------------------------------
`define ALB_OPC_HI      31
`define ALB_OPC_LO      26
`define ALB_DST_HI      25
`define ALB_DST_LO      21
`define ALB_SRCA_HI     20
`define ALB_SRCA_LO     16
`define ALB_SRCB_HI     15
`define ALB_SRCB_LO     11
`define ALB_LIT_HI      15
`define ALB_LIT_LO      0
`define ALB_TAIL_HI     10
`define ALB_KEEP_BIT    28
`define ALB_CIN_BIT     27
`define ALB_DLY_BIT     25
`define ALB_COND_HI     24
`define ALB_COND_LO     21

// ----------------------------------------------------------------
// opcodes and branch conditions
// ----------------------------------------------------------------
`define ALB_ADDI_GRP    3'h1
`define ALB_OP_AND      6'h21
`define ALB_OP_ANDN     6'h23
`define ALB_OP_ANDI     6'h29
`define ALB_OP_ANDNI    6'h2B
`define ALB_OP_BCC      6'h27
`define ALB_OP_BCCI     6'h2F
`define ALB_OP_PREFIX   6'h2C
`define ALB_COND_EQ     4'h0
`define ALB_COND_GE     4'h5

// ----------------------------------------------------------------
// apb register map and reset values
// ----------------------------------------------------------------
`define ALB_ADR_GPR_END 12'h07C
`define ALB_ADR_PC      12'h080
`define ALB_ADR_MSW     12'h084
`define ALB_ADR_STAT    12'h088
`define ALB_MSW_CARRY   0
`define ALB_PC_RST      32'h00000000
`define ALB_PC_STEP     32'h00000004
`define ALB_STALL_DLY   2'h1
`define ALB_STALL_NODLY 2'h2

`endif

// file: alb_exec.v
// execute unit for add-immediate, AND variants and compare-with-zero branches
`timescale 1ns/1ps
`include "alb_defs.vh"

module alb_exec #(
  parameter ADDR_W = 12
) (
  input  wire              ref_clk_in,
  input  wire              reset_in,
  input  wire              psel_in,
  input  wire              penable_in,
  input  wire              pwrite_in,
  input  wire [ADDR_W-1:0] paddr_in,
  input  wire [31:0]       pwdata_in,
  output reg  [31:0]       prdata_out,
  output reg               pready_out,
  output reg               pslverr_out,
  input  wire              issue_valid_in,
  input  wire [31:0]       issue_word_in,
  output reg               issue_ready_out,
  output reg  [31:0]       fetch_pc_out,
  output reg               fetch_discard_out,
  output reg               illegal_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [31:0] sext16;
    input [15:0] lit;
    begin
      sext16 = {{16{lit[15]}}, lit};
    end
  endfunction

  function [31:0] imm_operand;
    input        hold;
    input [15:0] upper;
    input [15:0] lit;
    begin
      if (hold) begin
        imm_operand = {upper, lit};
      end else begin
        imm_operand = sext16(lit);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [31:0] gpr [0:31];
  reg  [31:0] pc_reg;
  reg  [31:0] pc_next;
  reg         carry_reg;
  reg         carry_next;
  reg         prefix_hold_reg;
  reg         prefix_hold_next;
  reg  [15:0] prefix_upper_reg;
  reg  [15:0] prefix_upper_next;
  reg         dly_pend_reg;
  reg         dly_pend_next;
  reg  [31:0] dly_target_reg;
  reg  [31:0] dly_target_next;
  reg  [1:0]  stall_reg;
  reg  [1:0]  stall_next;
  reg         ready_next;
  reg         discard_next;
  reg         illegal_next;
  reg  [31:0] rdata_next;
  reg         slverr_next;
  integer     i;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire        accept   = issue_valid_in & issue_ready_out;
  wire [5:0]  opc      = issue_word_in[`ALB_OPC_HI:`ALB_OPC_LO];
  wire [4:0]  dst_idx  = issue_word_in[`ALB_DST_HI:`ALB_DST_LO];
  wire [4:0]  srca_idx = issue_word_in[`ALB_SRCA_HI:`ALB_SRCA_LO];
  wire [4:0]  srcb_idx = issue_word_in[`ALB_SRCB_HI:`ALB_SRCB_LO];
  wire [15:0] lit      = issue_word_in[`ALB_LIT_HI:`ALB_LIT_LO];
  wire [3:0]  cond     = issue_word_in[`ALB_COND_HI:`ALB_COND_LO];
  wire        dly_flag = issue_word_in[`ALB_DLY_BIT];
  wire        keep_c   = issue_word_in[`ALB_KEEP_BIT];
  wire        use_c    = issue_word_in[`ALB_CIN_BIT];
  wire        tail_nz  = |issue_word_in[`ALB_TAIL_HI:0];
  wire [31:0] srca     = gpr[srca_idx];
  wire [31:0] srcb     = gpr[srcb_idx];
  // a preceding prefix replaces the sign extension for one word only
  wire [31:0] immv     = imm_operand(prefix_hold_reg, prefix_upper_reg, lit);
  wire        is_addi  = (opc[5:3] == `ALB_ADDI_GRP) & ~opc[0];
  wire [32:0] add_sum  = {1'b0, srca} + {1'b0, immv} + {32'h0, use_c & carry_reg};

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  reg         wr_en;
  reg  [31:0] wr_val;
  reg         br_op;
  reg         br_taken;
  reg  [31:0] br_off;
  reg         bad_op;

  always @* begin
    wr_en    = 1'b0;
    wr_val   = 32'h0;
    br_op    = 1'b0;
    br_taken = 1'b0;
    br_off   = srcb;
    bad_op   = 1'b0;
    if (is_addi) begin
      wr_en  = 1'b1;
      wr_val = add_sum[31:0];
    end else begin
      case (opc)
        `ALB_OP_AND: begin
          wr_en  = 1'b1;
          wr_val = srca & srcb;
        end
        `ALB_OP_ANDN: begin
          wr_en  = 1'b1;
          wr_val = srca & ~srcb;
        end
        `ALB_OP_ANDI: begin
          wr_en  = 1'b1;
          wr_val = srca & immv;
        end
        `ALB_OP_ANDNI: begin
          wr_en  = 1'b1;
          wr_val = srca & ~immv;
        end
        `ALB_OP_BCC, `ALB_OP_BCCI: begin
          br_op = 1'b1;
          if (opc == `ALB_OP_BCCI) begin
            br_off = immv;
          end
          if ((opc == `ALB_OP_BCC) && tail_nz) begin
            bad_op = 1'b1;
          end else if (cond == `ALB_COND_EQ) begin
            br_taken = (srca == 32'h0);
          end else if (cond == `ALB_COND_GE) begin
            br_taken = ~srca[31];
          end else begin
            bad_op = 1'b1;
          end
        end
        // prefix only latches its literal, in the sequencing block
        `ALB_OP_PREFIX: begin
          wr_en = 1'b0;
        end
        default: begin
          bad_op = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequencing of pc, carry, prefix and stalls
  // ----------------------------------------------------------------
  always @* begin
    pc_next           = pc_reg;
    carry_next        = carry_reg;
    prefix_hold_next  = prefix_hold_reg;
    prefix_upper_next = prefix_upper_reg;
    dly_pend_next     = dly_pend_reg;
    dly_target_next   = dly_target_reg;
    stall_next        = stall_reg;
    ready_next        = 1'b1;
    discard_next      = 1'b0;
    illegal_next      = 1'b0;
    if (accept) begin
      prefix_hold_next = (opc == `ALB_OP_PREFIX);
      if (opc == `ALB_OP_PREFIX) begin
        prefix_upper_next = lit;
      end
      illegal_next = bad_op;
      if (is_addi && !keep_c) begin
        carry_next = add_sum[32];
      end
      if (dly_pend_reg) begin
        pc_next       = dly_target_reg;
        dly_pend_next = 1'b0;
      end else begin
        pc_next = pc_reg + `ALB_PC_STEP;
      end
      // a branch in a delay slot never redirects: the pending target wins
      if (br_op && br_taken && !bad_op && !dly_pend_reg) begin
        if (dly_flag) begin
          dly_pend_next   = 1'b1;
          dly_target_next = pc_reg + br_off;
          stall_next      = `ALB_STALL_DLY;
        end else begin
          pc_next      = pc_reg + br_off;
          discard_next = 1'b1;
          stall_next   = `ALB_STALL_NODLY;
        end
        ready_next = 1'b0;
      end
    end else if (stall_reg != 2'h0) begin
      // ready rises in the last stalled cycle, so the next word waits for its edge
      stall_next = stall_reg - 2'h1;
      ready_next = (stall_reg == 2'h1);
    end
  end

  // ----------------------------------------------------------------
  // apb read path
  // ----------------------------------------------------------------
  wire apb_gpr = (paddr_in <= `ALB_ADR_GPR_END);
  wire apb_hit = apb_gpr | (paddr_in == `ALB_ADR_PC) | (paddr_in == `ALB_ADR_MSW)
               | (paddr_in == `ALB_ADR_STAT);
  // writes commit on the first access edge, the same edge that raises pready
  wire apb_wr  = psel_in & penable_in & ~pready_out & pwrite_in & apb_hit;
  wire apb_pc_wr = apb_wr & ~accept & (paddr_in == `ALB_ADR_PC) & ~slverr_next;

  always @* begin
    rdata_next  = 32'h0;
    slverr_next = ~apb_hit | (paddr_in[1:0] != 2'h0);
    if (apb_gpr) begin
      rdata_next = gpr[paddr_in[6:2]];
    end else if (paddr_in == `ALB_ADR_PC) begin
      rdata_next = pc_reg;
    end else if (paddr_in == `ALB_ADR_MSW) begin
      rdata_next[`ALB_MSW_CARRY] = carry_reg;
    end else if (paddr_in == `ALB_ADR_STAT) begin
      rdata_next = {27'h0, illegal_out, prefix_hold_reg, dly_pend_reg, stall_reg != 2'h0,
                    issue_ready_out};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (i = 0; i < 32; i = i + 1) begin
        gpr[i] <= 32'h0;
      end
      pc_reg            <= `ALB_PC_RST;
      carry_reg         <= 1'b0;
      prefix_hold_reg   <= 1'b0;
      prefix_upper_reg  <= 16'h0;
      dly_pend_reg      <= 1'b0;
      dly_target_reg    <= 32'h0;
      stall_reg         <= 2'h0;
      // ready comes up on the first edge after release
      issue_ready_out   <= 1'b0;
      fetch_pc_out      <= `ALB_PC_RST;
      fetch_discard_out <= 1'b0;
      illegal_out       <= 1'b0;
      prdata_out        <= 32'h0;
      pready_out        <= 1'b0;
      pslverr_out       <= 1'b0;
    end else begin
      // instruction results take precedence over a colliding apb write
      if (accept && wr_en && !bad_op) begin
        gpr[dst_idx] <= wr_val;
      end else if (apb_wr && apb_gpr && !slverr_next) begin
        gpr[paddr_in[6:2]] <= pwdata_in;
      end
      if (apb_pc_wr) begin
        pc_reg <= pwdata_in;
      end else begin
        pc_reg <= pc_next;
      end
      // software rewrites carry only in a cycle where no word is taken
      if (apb_wr && !accept && (paddr_in == `ALB_ADR_MSW)) begin
        carry_reg <= pwdata_in[`ALB_MSW_CARRY];
      end else begin
        carry_reg <= carry_next;
      end
      prefix_hold_reg   <= prefix_hold_next;
      prefix_upper_reg  <= prefix_upper_next;
      dly_pend_reg      <= dly_pend_next;
      dly_target_reg    <= dly_target_next;
      stall_reg         <= stall_next;
      issue_ready_out   <= ready_next;
      if (apb_pc_wr) begin
        fetch_pc_out <= pwdata_in;
      end else begin
        fetch_pc_out <= pc_next;
      end
      fetch_discard_out <= discard_next;
      illegal_out       <= illegal_next;
      // one-cycle pready pulse; read data and error stand only with it
      pready_out        <= psel_in & penable_in & ~pready_out;
      if (psel_in && penable_in && !pready_out) begin
        prdata_out  <= pwrite_in ? 32'h0 : rdata_next;
        pslverr_out <= slverr_next;
      end else begin
        prdata_out  <= 32'h0;
        pslverr_out <= 1'b0;
      end
    end
  end

endmodule // alb_exec

// file: alb_exec_chk.sv
// assertion checker for the execute slice issue port
`timescale 1ns/1ps
`include "alb_defs.vh"
module alb_exec_chk (
  input wire        ref_clk_in,
  input wire        reset_in,
  input wire        issue_valid_in,
  input wire [31:0] issue_word_in,
  input wire        issue_ready_out,
  input wire [31:0] fetch_pc_out,
  input wire        fetch_discard_out,
  input wire        illegal_out
);
  wire [5:0] op  = issue_word_in[31:26];
  wire [3:0] cnd = issue_word_in[`ALB_COND_HI:`ALB_COND_LO];
  wire       tk  = issue_valid_in && issue_ready_out;
  wire       br  = (op == `ALB_OP_BCC) || (op == `ALB_OP_BCCI);
  wire       dly = br && issue_word_in[`ALB_DLY_BIT];
  wire       alu = (op[5:3] == `ALB_ADDI_GRP && !op[0]) || op == `ALB_OP_AND
                   || op == `ALB_OP_ANDN || op == `ALB_OP_ANDI || op == `ALB_OP_ANDNI;
  wire       bad = br && ((op == `ALB_OP_BCC && issue_word_in[10:0] != 11'h0)
                   || (cnd != `ALB_COND_EQ && cnd != `ALB_COND_GE));
  reg        slot_reg;
  // slot words follow a pending target, so pc checks skip them
  wire       fr  = tk && !slot_reg;
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in)
      slot_reg <= 1'b0;
    else if (tk)
      slot_reg <= dly;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  property p_step; fr && alu |=> fetch_pc_out == $past(fetch_pc_out) + 32'h4; endproperty
  a_step: assert property (p_step) else $error("alu word did not step pc");
  property p_untaken;
    fr && br && !bad ##1 issue_ready_out |-> fetch_pc_out == $past(fetch_pc_out) + 32'h4;
  endproperty
  a_untaken: assert property (p_untaken) else $error("untaken branch pc wrong");
  property p_nodly; fr && br && !dly && !bad ##1 !issue_ready_out |-> fetch_discard_out; endproperty
  a_nodly: assert property (p_nodly) else $error("no discard on taken branch");
  property p_discard;
    fetch_discard_out |-> !issue_ready_out ##1 !issue_ready_out ##1 issue_ready_out;
  endproperty
  a_discard: assert property (p_discard) else $error("taken branch stall not 3");
  property p_dly; fr && dly && !bad ##1 !issue_ready_out |=> issue_ready_out; endproperty
  a_dly: assert property (p_dly) else $error("delay branch stall not 2");
  property p_dly_pc;
    fr && dly && !bad ##1 !issue_ready_out |-> !fetch_discard_out
      && fetch_pc_out == $past(fetch_pc_out) + 32'h4;
  endproperty
  a_dly_pc: assert property (p_dly_pc) else $error("delay slot not fetched");
  property p_bad; fr && bad |=> illegal_out && fetch_pc_out == $past(fetch_pc_out) + 32'h4;
  endproperty
  a_bad: assert property (p_bad) else $error("bad branch form accepted");
  property p_other; fr && !alu && !br && op != `ALB_OP_PREFIX |=> illegal_out; endproperty
  a_other: assert property (p_other) else $error("unknown opcode not flagged");
  c_disc: cover property (fetch_discard_out);
  c_dly: cover property (fr && dly ##1 !issue_ready_out);
  c_bad: cover property (fr && bad);
endmodule // alb_exec_chk

bind alb_exec alb_exec_chk chk_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .issue_valid_in(issue_valid_in), .issue_word_in(issue_word_in),
  .issue_ready_out(issue_ready_out), .fetch_pc_out(fetch_pc_out),
  .fetch_discard_out(fetch_discard_out), .illegal_out(illegal_out));

// file: alb_fetch_model.sv
// instruction memory model feeding the issue port
`timescale 1ns/1ps
module alb_fetch_model (
  input  wire        valid_in,
  input  wire [31:0] pc_in,
  output wire [31:0] word_out
);
  logic [31:0] mem [0:63];
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'h0;
    end
  end
  // idle bus shows the inverted word, never a stale one
  assign word_out = valid_in ? mem[pc_in[7:2]] : ~mem[pc_in[7:2]];
endmodule // alb_fetch_model

// file: tb_top.sv
// self-checking bench for the execute slice
`timescale 1ns/1ps
`include "alb_defs.vh"
module tb_top;
  typedef struct packed {logic [31:0] w, a, b, d, pc; logic [1:0] cc;} alb_row_t;
  logic        ref_clk_in, reset_in, psel_in, penable_in, pwrite_in, issue_valid_in;
  logic        pready_out, pslverr_out, issue_ready_out, fetch_discard_out, illegal_out, er;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, issue_word_in, fetch_pc_out, rdv;
  int          errors, check_count;
  alb_row_t    rows [13] = '{
    '{32'h2061FFFE, 32'h1, 32'h0, 32'hFFFFFFFF, 32'h44, 2'h2},
    '{32'h2861FFFF, 32'h1, 32'h0, 32'h1, 32'h44, 2'h3},
    '{32'h30610001, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h44, 2'h0},
    '{32'h38618000, 32'h5, 32'h0, 32'hFFFF8006, 32'h44, 2'h3},
    '{32'h84611000, 32'hF0F0F0F0, 32'hFF00FF00, 32'hF000F000, 32'h44, 2'h3},
    '{32'h8C611000, 32'hF0F0F0F0, 32'hFF00FF00, 32'h00F000F0, 32'h44, 2'h0},
    '{32'hA4618F0F, 32'hF0F0F0F0, 32'h0, 32'hF0F08000, 32'h44, 2'h3},
    '{32'hAC61800F, 32'hFFFFFFFF, 32'h0, 32'h00007FF0, 32'h44, 2'h0},
    '{32'h9CA11000, 32'h7FFFFFFF, 32'hFFFFFFF8, 32'hA5A5A5A5, 32'h38, 2'h3},
    '{32'h9CA11000, 32'h80000000, 32'hFFFFFFF8, 32'hA5A5A5A5, 32'h44, 2'h0},
    '{32'hBCA1FFF0, 32'h0, 32'h0, 32'hA5A5A5A5, 32'h30, 2'h3},
    '{32'h9C011001, 32'h0, 32'h10, 32'hA5A5A5A5, 32'h44, 2'h0},
    '{32'hFC000000, 32'h0, 32'h0, 32'hA5A5A5A5, 32'h44, 2'h3}};

  alb_exec dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .issue_valid_in(issue_valid_in),
    .issue_word_in(issue_word_in), .issue_ready_out(issue_ready_out),
    .fetch_pc_out(fetch_pc_out), .fetch_discard_out(fetch_discard_out),
    .illegal_out(illegal_out));
  alb_fetch_model fm_u (.valid_in(issue_valid_in), .pc_in(fetch_pc_out),
    .word_out(issue_word_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  // ----------------------------------------
  // bus, issue and compare tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do @(posedge ref_clk_in); while (pready_out !== 1'b1);
    rdv = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic run(input int n);
    int k;
    k = 0;
    issue_valid_in <= 1'b1;
    while (k < n) begin
      @(posedge ref_clk_in);
      if (issue_ready_out === 1'b1)
        k++;
    end
    issue_valid_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    {reset_in, psel_in, penable_in, pwrite_in, issue_valid_in} = 5'h10;
    paddr_in = 12'h0;
    pwdata_in = 32'h0;
    repeat (12) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      wr(12'h004, rows[i].a);
      wr(12'h008, rows[i].b);
      wr(12'h00C, 32'hA5A5A5A5);
      wr(`ALB_ADR_MSW, {31'h0, rows[i].cc[1]});
      wr(`ALB_ADR_PC, 32'h40);
      fm_u.mem[16] = rows[i].w;
      run(1);
      rd(12'h00C);
      check(rdv, rows[i].d);
      rd(`ALB_ADR_MSW);
      check({31'h0, rdv[0]}, {31'h0, rows[i].cc[0]});
      check(fetch_pc_out, rows[i].pc);
    end
    wr(12'h004, 32'h0);
    wr(12'h008, 32'h20);
    wr(`ALB_ADR_PC, 32'h40);
    fm_u.mem[16] = 32'h9E011000;
    fm_u.mem[17] = 32'h30610007;
    fm_u.mem[18] = 32'h30A10001;
    fm_u.mem[24] = 32'h30810009;
    run(3);
    rd(12'h00C);
    check(rdv, 32'h7);
    rd(12'h014);
    check(rdv, 32'h0);
    rd(12'h010);
    check(rdv, 32'h9);
    check(fetch_pc_out, 32'h64);
    wr(`ALB_ADR_PC, 32'h40);
    fm_u.mem[16] = 32'hBC010010;
    fm_u.mem[17] = 32'h30E10005;
    fm_u.mem[20] = 32'h30C10003;
    run(2);
    rd(12'h018);
    check(rdv, 32'h3);
    rd(12'h01C);
    check(rdv, 32'h0);
    wr(`ALB_ADR_PC, 32'h40);
    fm_u.mem[16] = 32'hB0001234;
    fm_u.mem[17] = 32'h30615678;
    fm_u.mem[18] = 32'h31018000;
    run(3);
    rd(12'h00C);
    check(rdv, 32'h12345678);
    rd(12'h020);
    check(rdv, 32'hFFFF8000);
    rd(12'h100);
    check({31'h0, er}, 32'h1);
    reset_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    rd(12'h00C);
    check(rdv, 32'h0);
    check(fetch_pc_out, 32'h0);
    print_verdict;
  end

  initial begin
    #200000;
    errors++;
    print_verdict;
  end
endmodule // tb_top
